// File: rtl/albd_core.sv
// Decode and execute unit for a small arithmetic, logic and branch subset.
// Assumes an APB master on the same clock; instructions arrive by register.
`timescale 1ns/100ps
module albd_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [albd_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  albd_pkg::albd_state_t state_reg;
  albd_pkg::albd_state_t state_next;
  logic [1:0] nopCnt_reg;
  logic [albd_pkg::INSTR_W-1:0] instr_reg;
  logic [albd_pkg::DATA_W-1:0] wAcc_reg;
  logic [albd_pkg::STATUS_W-1:0] status_reg;
  logic [albd_pkg::BANK_W-1:0] bankSel_reg;
  logic [albd_pkg::PC_W-1:0] pc_reg;
  logic extEnable_reg;
  logic [albd_pkg::ADDR_W-1:0] indexBase_reg;
  logic [albd_pkg::ADDR_W-1:0] dataAddr_reg;
  logic [albd_pkg::DATA_W-1:0] operand_reg;

  // Instruction fields
  wire logic [albd_pkg::DATA_W-1:0] fAddr = instr_reg[7:0];
  wire logic destBit = instr_reg[albd_pkg::IN_DEST];
  wire logic bankBit = instr_reg[albd_pkg::IN_ABIT];
  wire logic [2:0] bitSel = instr_reg[albd_pkg::IN_BIT_LO +: 3];
  wire logic isAddc = instr_reg[15:10] == albd_pkg::OP6_ADDC;
  wire logic isAddf = instr_reg[15:10] == albd_pkg::OP6_ADDF;
  wire logic isAndf = instr_reg[15:10] == albd_pkg::OP6_ANDF;
  wire logic isAndl = instr_reg[15:8] == albd_pkg::OP8_ANDL;
  wire logic isBclr = instr_reg[15:12] == albd_pkg::OP4_BCLR;
  wire logic isBrc = instr_reg[15:8] == albd_pkg::OP8_BRC;
  wire logic isBrn = instr_reg[15:8] == albd_pkg::OP8_BRN;
  wire logic addOp = isAddc | isAddf;
  wire logic byteOp = addOp | isAndf;
  wire logic fileOp = byteOp | isBclr;
  wire logic busy = state_reg != albd_pkg::S_IDLE;

  // Effective file address
  wire logic lowHalf = fAddr <= albd_pkg::ACCESS_LIMIT;
  wire logic indexed = fileOp & ~bankBit & extEnable_reg & lowHalf;
  wire logic [albd_pkg::ADDR_W-1:0] accessAddr = lowHalf ?
    {albd_pkg::ACCESS_LO_BANK, fAddr} :
    {albd_pkg::ACCESS_HI_BANK, fAddr};
  wire logic [albd_pkg::ADDR_W-1:0] indexAddr =
    indexBase_reg + {albd_pkg::ACCESS_LO_BANK, fAddr};
  wire logic [albd_pkg::ADDR_W-1:0] fileAddr = indexed ? indexAddr :
    (bankBit ? {bankSel_reg, fAddr} : accessAddr);

  // Arithmetic and logic
  wire logic carryIn = isAddc & status_reg[albd_pkg::ST_C];
  wire logic [8:0] sum9 = {1'b0, wAcc_reg} + {1'b0, operand_reg} +
    {8'h00, carryIn};
  wire logic [4:0] sum5 = {1'b0, wAcc_reg[3:0]} + {1'b0, operand_reg[3:0]} +
    {4'h0, carryIn};
  wire logic ovf = (wAcc_reg[7] == operand_reg[7]) &
    (sum9[7] != wAcc_reg[7]);
  wire logic [albd_pkg::DATA_W-1:0] andRes =
    wAcc_reg & (isAndl ? fAddr : operand_reg);
  wire logic [albd_pkg::DATA_W-1:0] bitMask = 8'h01 << bitSel;
  wire logic [albd_pkg::DATA_W-1:0] clrRes = operand_reg & ~bitMask;
  wire logic [albd_pkg::DATA_W-1:0] result = addOp ? sum9[7:0] :
    ((isAndf | isAndl) ? andRes : clrRes);
  wire logic resZero = result == 8'h00;
  wire logic [albd_pkg::STATUS_W-1:0] statusAdd =
    {result[7], ovf, resZero, sum5[4], sum9[8]};
  wire logic [albd_pkg::STATUS_W-1:0] statusAnd =
    {result[7], status_reg[albd_pkg::ST_OV], resZero,
     status_reg[albd_pkg::ST_DC], status_reg[albd_pkg::ST_C]};

  // Branch decision and target
  wire logic taken = (isBrc & status_reg[albd_pkg::ST_C]) |
    (isBrn & status_reg[albd_pkg::ST_N]);
  wire logic [albd_pkg::PC_W-1:0] branchOff =
    {{(albd_pkg::PC_W-9){fAddr[7]}}, fAddr, 1'b0};
  wire logic [albd_pkg::PC_W-1:0] branchTarget = pc_reg + branchOff;
  wire logic [albd_pkg::PC_W-1:0] pcInc = pc_reg + albd_pkg::PC_STEP;

  // Phase strobes
  wire logic inDecode = state_reg == albd_pkg::S_DECODE;
  wire logic inProcess = state_reg == albd_pkg::S_PROCESS;
  wire logic inWrite = state_reg == albd_pkg::S_WRITE;
  wire logic writeFile = inWrite & ((byteOp & destBit) | isBclr);
  wire logic writeAcc = inWrite & ((byteOp & ~destBit) | isAndl);
  wire logic writeStatus = inWrite & (byteOp | isAndl);
  wire logic writePc = inWrite & taken;

  // APB decode
  wire logic apbAccess = psel & penable;
  wire logic apbFirst = apbAccess & ~pready;
  wire logic apbDone = apbAccess & pready;
  wire logic apbWrite = apbDone & pwrite & ~pslverr;
  wire logic hitCtrl = paddr == albd_pkg::OFF_CTRL;
  wire logic hitStatus = paddr == albd_pkg::OFF_STATUS;
  wire logic hitWacc = paddr == albd_pkg::OFF_WREG;
  wire logic hitBank = paddr == albd_pkg::OFF_BANK;
  wire logic hitPc = paddr == albd_pkg::OFF_PC;
  wire logic hitIndex = paddr == albd_pkg::OFF_INDEX;
  wire logic hitInstr = paddr == albd_pkg::OFF_INSTR;
  wire logic hitDaddr = paddr == albd_pkg::OFF_DADDR;
  wire logic hitDdata = paddr == albd_pkg::OFF_DDATA;
  wire logic mapped = hitCtrl | hitStatus | hitWacc | hitBank | hitPc |
    hitIndex | hitInstr | hitDaddr | hitDdata;
  wire logic refuse = ~mapped | (busy & (pwrite | hitDdata));
  wire logic startExec = apbWrite & hitInstr;

  // Memory port: core owns it while busy
  wire logic ramWe = writeFile | (apbWrite & hitDdata);
  wire logic [albd_pkg::ADDR_W-1:0] ramAddr = busy ? fileAddr : dataAddr_reg;
  wire logic [albd_pkg::DATA_W-1:0] ramWrData = busy ? result : pwdata[7:0];
  logic [albd_pkg::DATA_W-1:0] ramRdData;

  logic [31:0] readMux;
  always_comb
  begin
    readMux = albd_pkg::RD_ZERO;
    unique case (1'b1)
      hitCtrl: readMux[albd_pkg::CTRL_EXT] = extEnable_reg;
      hitStatus:
      begin
        readMux[albd_pkg::STATUS_W-1:0] = status_reg;
        readMux[albd_pkg::ST_BUSY] = busy;
      end
      hitWacc: readMux[albd_pkg::DATA_W-1:0] = wAcc_reg;
      hitBank: readMux[albd_pkg::BANK_W-1:0] = bankSel_reg;
      hitPc: readMux[albd_pkg::PC_W-1:0] = pc_reg;
      hitIndex: readMux[albd_pkg::ADDR_W-1:0] = indexBase_reg;
      hitInstr: readMux[albd_pkg::INSTR_W-1:0] = instr_reg;
      hitDaddr: readMux[albd_pkg::ADDR_W-1:0] = dataAddr_reg;
      hitDdata: readMux[albd_pkg::DATA_W-1:0] = ramRdData;
      default: readMux = albd_pkg::RD_ZERO;
    endcase
  end

  // Phase sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      albd_pkg::S_IDLE:
        if (startExec)
          state_next = albd_pkg::S_DECODE;
      albd_pkg::S_DECODE: state_next = albd_pkg::S_READ;
      albd_pkg::S_READ: state_next = albd_pkg::S_PROCESS;
      albd_pkg::S_PROCESS: state_next = albd_pkg::S_WRITE;
      albd_pkg::S_WRITE:
        state_next = taken ? albd_pkg::S_NOP : albd_pkg::S_IDLE;
      albd_pkg::S_NOP:
        if (nopCnt_reg == albd_pkg::NOP_LAST)
          state_next = albd_pkg::S_IDLE;
      default: state_next = albd_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= albd_pkg::S_IDLE;
      nopCnt_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      nopCnt_reg <= (state_reg == albd_pkg::S_NOP) ? nopCnt_reg + 2'h1 : 2'h0;
    end
  end

  // Execution state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wAcc_reg <= 8'h00;
      status_reg <= 5'h00;
      pc_reg <= 21'h000000;
      operand_reg <= 8'h00;
    end
    else
    begin
      if (inProcess)
        operand_reg <= ramRdData;
      if (writeAcc | (apbWrite & hitWacc))
        wAcc_reg <= busy ? result : pwdata[7:0];
      if (writeStatus)
        status_reg <= addOp ? statusAdd : statusAnd;
      else if (apbWrite & hitStatus)
        status_reg <= pwdata[albd_pkg::STATUS_W-1:0];
      if (inDecode)
        pc_reg <= pcInc;
      else if (writePc)
        pc_reg <= branchTarget;
      else if (apbWrite & hitPc)
        pc_reg <= pwdata[albd_pkg::PC_W-1:0];
    end
  end

  // Software-written configuration
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      instr_reg <= 16'h0000;
      bankSel_reg <= 4'h0;
      extEnable_reg <= 1'b0;
      indexBase_reg <= 12'h000;
      dataAddr_reg <= 12'h000;
    end
    else if (apbWrite)
    begin
      if (hitInstr)
        instr_reg <= pwdata[albd_pkg::INSTR_W-1:0];
      if (hitBank)
        bankSel_reg <= pwdata[albd_pkg::BANK_W-1:0];
      if (hitCtrl)
        extEnable_reg <= pwdata[albd_pkg::CTRL_EXT];
      if (hitIndex)
        indexBase_reg <= pwdata[albd_pkg::ADDR_W-1:0];
      if (hitDaddr)
        dataAddr_reg <= pwdata[albd_pkg::ADDR_W-1:0];
    end
  end

  // APB answer: one wait state on every transfer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= albd_pkg::RD_ZERO;
    end
    else
    begin
      pready <= apbFirst;
      pslverr <= apbFirst & refuse;
      prdata <= (apbFirst & ~pwrite & ~refuse) ? readMux : albd_pkg::RD_ZERO;
    end
  end

  albd_data_ram #(
    .AW(albd_pkg::ADDR_W),
    .DW(albd_pkg::DATA_W)
  ) u_ram (
    .clock(clock),
    .we(ramWe),
    .addr(ramAddr),
    .wrData(ramWrData),
    .rdData(ramRdData)
  );

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_addc_acc;
    inWrite && isAddc && !destBit |=>
      wAcc_reg == 8'($past(wAcc_reg) + $past(operand_reg) +
      {7'h00, $past(status_reg[albd_pkg::ST_C])});
  endproperty
  a_addc_acc: assert property (p_addc_acc)
    else $error("add with carry result wrong");

  property p_dest_file;
    inWrite && byteOp && destBit |-> ramWe && ramAddr == fileAddr
      ##1 $stable(wAcc_reg);
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not honoured");

  property p_bank;
    state_reg == albd_pkg::S_READ && fileOp && bankBit |->
      ramAddr == {bankSel_reg, fAddr};
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select address wrong");

  property p_indexed;
    state_reg == albd_pkg::S_READ && fileOp && !bankBit && extEnable_reg &&
      fAddr <= albd_pkg::ACCESS_LIMIT |->
      ramAddr == 12'(indexBase_reg + {4'h0, fAddr});
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");

  property p_andl;
    inWrite && isAndl |=> wAcc_reg == ($past(wAcc_reg) & $past(fAddr)) &&
      status_reg[2:0] == {(wAcc_reg == 8'h00), $past(status_reg[1:0])} &&
      $stable(status_reg[albd_pkg::ST_OV]);
  endproperty
  a_andl: assert property (p_andl)
    else $error("and literal wrong");

  property p_taken;
    inWrite && taken |=>
      pc_reg == $past(pc_reg) + $past(branchOff) && $stable(status_reg)
      ##0 state_reg == albd_pkg::S_NOP [*4] ##1 state_reg == albd_pkg::S_IDLE;
  endproperty
  a_taken: assert property (p_taken)
    else $error("taken branch wrong");

  property p_untaken;
    inWrite && (isBrc || isBrn) && !taken |=>
      state_reg == albd_pkg::S_IDLE && $stable(pc_reg) && $stable(status_reg);
  endproperty
  a_untaken: assert property (p_untaken)
    else $error("untaken branch wrong");

  property p_bclr;
    inWrite && isBclr |-> ramWe && ramWrData[bitSel] == 1'b0 &&
      (ramWrData | bitMask) == (operand_reg | bitMask) ##1 $stable(status_reg);
  endproperty
  a_bclr: assert property (p_bclr)
    else $error("bit clear wrong");

  property p_carry;
    inWrite && addOp |=> status_reg[albd_pkg::ST_C] == $past(sum9[8]) &&
      status_reg[albd_pkg::ST_DC] == $past(sum5[4]);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flags wrong");

  property p_phases;
    inDecode |=> state_reg == albd_pkg::S_READ ##1 inProcess ##1 inWrite;
  endproperty
  a_phases: assert property (p_phases)
    else $error("phase order wrong");

  c_addc: cover property (inWrite && isAddc && destBit);
  c_taken: cover property (inWrite && taken);
  c_bclr_idx: cover property (inWrite && isBclr && indexed);
  c_refused: cover property (pready && pslverr);

endmodule : albd_core

// File: rtl/albd_pkg.sv
// Constants, opcodes, register map and state type for the decode unit.
// Assumes an APB slave with byte addresses and 32-bit data words.
package albd_pkg;

  // Datapath widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam int INSTR_W = 16;
  localparam int STATUS_W = 5;
  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFF_WREG = 8'h08;
  localparam logic [APB_AW-1:0] OFF_BANK = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_PC = 8'h10;
  localparam logic [APB_AW-1:0] OFF_INDEX = 8'h14;
  localparam logic [APB_AW-1:0] OFF_INSTR = 8'h18;
  localparam logic [APB_AW-1:0] OFF_DADDR = 8'h1c;
  localparam logic [APB_AW-1:0] OFF_DDATA = 8'h20;

  // Field positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_BUSY = 8;
  localparam int CTRL_EXT = 0;
  localparam int IN_DEST = 9;
  localparam int IN_ABIT = 8;
  localparam int IN_BIT_LO = 9;

  // Opcode fields
  localparam logic [5:0] OP6_ADDC = 6'h08;
  localparam logic [5:0] OP6_ADDF = 6'h09;
  localparam logic [5:0] OP6_ANDF = 6'h05;
  localparam logic [7:0] OP8_ANDL = 8'h0b;
  localparam logic [7:0] OP8_BRC = 8'he2;
  localparam logic [7:0] OP8_BRN = 8'he6;
  localparam logic [3:0] OP4_BCLR = 4'h9;

  // Addressing
  localparam logic [DATA_W-1:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

  // Timing and reset values
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [1:0] NOP_LAST = 2'h3;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DECODE = 3'b001,
    S_READ = 3'b010,
    S_PROCESS = 3'b011,
    S_WRITE = 3'b100,
    S_NOP = 3'b101
  } albd_state_t;

endpackage : albd_pkg

// File: rtl/albd_data_ram.sv
// Banked data memory for the decode unit, one port, registered read.
// Assumes one write or read address per cycle from the core.
`timescale 1ns/100ps
module albd_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wrData,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read data always from a register
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end

endmodule : albd_data_ram

// File: tb/albd_apb_master.sv
// APB master model that drives the decode unit's register bus.
// Assumes one clock; the slave answers with pready, sampled at the edge.
`timescale 1ns/100ps
module albd_apb_master (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [albd_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  task automatic xfer(input logic wr, input logic [albd_pkg::APB_AW-1:0] a,
    input logic [31:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready is sampled high
    for (int n = 0; n < 16 && !ok; n++)
    begin
      @(posedge clock);
      ok = (pready === 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse, not a stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : albd_apb_master

// File: tb/tb.sv
// Self-checking bench for the decode unit, run through its register bus.
// Assumes the APB master model; a reference model predicts the reads that follow each instruction.
`timescale 1ns/100ps
module tb;
  localparam int AW = albd_pkg::APB_AW;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel;
  logic penable;
  logic pwrite;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [32:0] expQ[$];
  logic [32:0] got;
  logic [32:0] ex;
  int fails = 0;
  int checksDone = 0;
  logic [7:0] w;
  logic [4:0] st;
  logic [20:0] pc;
  logic [3:0] bank;
  logic [11:0] idx;
  logic ext;
  logic tk;
  logic [11:0] ma;
  logic [7:0] mem [4096];
  logic [7:0] ops [7] = '{8'h20, 8'h24, 8'h14, 8'h0b, 8'he2, 8'he6, 8'h90};
  logic [7:0] msk [7] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h0f};
  logic [7:0] fs [4] = '{8'h5f, 8'h60, 8'h00, 8'hff};

  always #20 clock = ~clock;

  albd_core dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  albd_apb_master mst (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready)
  );

  always @(posedge clock)
    if (pready === 1'b1)
    begin
      got = {pslverr, prdata};
      // An answer with no note fails on purpose
      ex = expQ.size() > 0 ? expQ.pop_front() : 33'h15a5a5a5a;
      checksDone++;
      if (got !== ex)
      begin
        fails++;
        $display("ERROR %0t exp %h got %h", $time, ex, got);
      end
    end

  task automatic results();
    if (fails == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic xf(input logic wr, input logic [AW-1:0] a,
    input logic [31:0] d, input logic er, input logic [31:0] e);
    bit ok;
    expQ.push_back({er, e});
    mst.xfer(wr, a, d, ok);
    if (!ok)
    begin
      fails++;
      results();
    end
  endtask : xf

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 1'b0, 32'h0);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0, 1'b0, e);
  endtask : rd

  function automatic logic [11:0] fa(input logic [7:0] f, input logic a);
    if (a)
      return {bank, f};
    if (ext && f <= albd_pkg::ACCESS_LIMIT)
      return idx + {4'h0, f};
    if (f <= albd_pkg::ACCESS_LIMIT)
      return {albd_pkg::ACCESS_LO_BANK, f};
    return {albd_pkg::ACCESS_HI_BANK, f};
  endfunction : fa

  task automatic put(input logic [7:0] r, input logic d);
    if (d)
      mem[ma] = r;
    else
      w = r;
    st[albd_pkg::ST_N] = r[7];
    st[albd_pkg::ST_Z] = (r == 8'h00);
  endtask : put

  task automatic model(input logic [15:0] i);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] m;
    logic c;
    ma = fa(i[7:0], i[8]);
    m = mem[ma];
    c = (i[15:10] == albd_pkg::OP6_ADDC) & st[albd_pkg::ST_C];
    pc = pc + albd_pkg::PC_STEP;
    tk = 1'b0;
    if (i[15:12] == albd_pkg::OP4_BCLR)
      mem[ma][i[11:9]] = 1'b0;
    else if (i[15:8] == albd_pkg::OP8_ANDL)
      put(w & i[7:0], 1'b0);
    else if (i[15:10] == albd_pkg::OP6_ANDF)
      put(w & m, i[9]);
    else if (i[15:10] == albd_pkg::OP6_ADDC
      || i[15:10] == albd_pkg::OP6_ADDF)
    begin
      s = w + m + c;
      h = w[3:0] + m[3:0] + c;
      st[albd_pkg::ST_C] = s[8];
      st[albd_pkg::ST_DC] = h[4];
      st[albd_pkg::ST_OV] = (w[7] == m[7]) && (s[7] != w[7]);
      put(s[7:0], i[9]);
    end
    else if ((i[15:8] == albd_pkg::OP8_BRC && st[albd_pkg::ST_C])
      || (i[15:8] == albd_pkg::OP8_BRN && st[albd_pkg::ST_N]))
    begin
      tk = 1'b1;
      pc = pc + {{12{i[7]}}, i[7:0], 1'b0};
    end
  endtask : model

  task automatic trial(input int k);
    logic [15:0] i;
    logic [4:0] s0;
    i[15:8] = ops[k] | (8'($urandom) & msk[k]);
    i[7:0] = 8'($urandom);
    // Bias towards the access-bank boundary
    if (i[6:5] == 2'b00)
      i[7:0] = fs[i[1:0]];
    w = 8'($urandom);
    st = 5'($urandom);
    pc = 21'($urandom);
    bank = 4'($urandom);
    idx = 12'($urandom);
    ext = 1'($urandom);
    wr(albd_pkg::OFF_CTRL, 32'(ext));
    wr(albd_pkg::OFF_WREG, 32'(w));
    wr(albd_pkg::OFF_STATUS, 32'(st));
    wr(albd_pkg::OFF_BANK, 32'(bank));
    wr(albd_pkg::OFF_INDEX, 32'(idx));
    wr(albd_pkg::OFF_PC, 32'(pc));
    ma = fa(i[7:0], i[8]);
    mem[ma] = 8'($urandom);
    wr(albd_pkg::OFF_DADDR, 32'(ma));
    wr(albd_pkg::OFF_DDATA, 32'(mem[ma]));
    s0 = st;
    model(i);
    wr(albd_pkg::OFF_INSTR, 32'(i));
    rd(albd_pkg::OFF_STATUS, {23'h0, 1'b1, 3'h0, s0});
    rd(albd_pkg::OFF_STATUS, {23'h0, tk, 3'h0, st});
    repeat (8) @(posedge clock);
    rd(albd_pkg::OFF_WREG, 32'(w));
    rd(albd_pkg::OFF_PC, 32'(pc));
    wr(albd_pkg::OFF_DADDR, 32'(ma));
    rd(albd_pkg::OFF_DDATA, 32'(mem[ma]));
  endtask : trial

  initial
  begin
    void'($urandom(65));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++)
      rd(8'(4 * k), 32'h0);
    xf(1'b0, 8'h24, 32'h0, 1'b1, 32'h0);
    xf(1'b1, 8'hfc, 32'h1, 1'b1, 32'h0);
    for (int k = 0; k < 70; k++)
      trial(k % 7);
    // Taken branch with the most negative offset, pokes while busy
    st[albd_pkg::ST_C] = 1'b1;
    wr(albd_pkg::OFF_STATUS, 32'(st));
    model(16'he280);
    wr(albd_pkg::OFF_INSTR, 32'he280);
    xf(1'b1, albd_pkg::OFF_WREG, 32'h5a, 1'b1, 32'h0);
    xf(1'b0, albd_pkg::OFF_DDATA, 32'h0, 1'b1, 32'h0);
    repeat (8) @(posedge clock);
    rd(albd_pkg::OFF_WREG, 32'(w));
    rd(albd_pkg::OFF_PC, 32'(pc));
    repeat (4) @(posedge clock);
    if (expQ.size() != 0)
      fails++;
    results();
  end
endmodule : tb
